// ===== hdl/rss_top.sv
`timescale 1ns/10ps
`default_nettype none
module rss_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  input  wire logic        op_busy,
  input  wire logic        op_summary,
  output logic             srq
);
  // ----------------------------------------
  // Receive line synchroniser and framer
  // ----------------------------------------
  logic        rx_s1_q;
  logic        rx_s2_q;
  logic        rx_act_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [8:0]  rx_sh_q;
  logic        rx_done_q;
  logic        rx_perr_q;
  logic        rx_ferr_q;
  logic [6:0]  rx_ch_q;
  wire         rx_tick   = rx_act_q & (rx_cnt_q == '0);
  wire         rx_start  = ~rx_act_q & ~rx_s2_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Sample mid-bit; a false start bit is dropped at its centre
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_act_q  <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_done_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_ch_q   <= '0;
    end else begin
      rx_done_q <= 1'b0;
      if (rx_start) begin
        rx_act_q <= 1'b1;
        rx_cnt_q <= rss_pkg::HALF_CNT;
        rx_bit_q <= '0;
      end else if (rx_act_q) begin
        rx_cnt_q <= rx_tick ? rss_pkg::BIT_CNT_MAX : rx_cnt_q - 16'h0001;
        if (rx_tick) begin
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == '0 && rx_s2_q) begin
            rx_act_q <= 1'b0;
          end else if (rx_bit_q == rss_pkg::FRAME_LAST) begin
            rx_act_q  <= 1'b0;
            rx_done_q <= 1'b1;
            // Eight shifts leave the first data bit at index 1; index 0 is stale
            rx_ch_q   <= rx_sh_q[7:1];
            rx_perr_q <= ~(^rx_sh_q[8:1]);
            rx_ferr_q <= ~rx_s2_q;
          end else if (rx_bit_q != '0) begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]};
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Message parser for the completion commands and *RST
  // ----------------------------------------
  logic [34:0] seg_q;
  logic [2:0]  seg_len_q;
  logic        opc_arm_q;
  logic        opcq_pend_q;
  wire         ch_lf     = rx_done_q & (rx_ch_q == rss_pkg::CH_LF);
  wire         ch_sep    = rx_done_q & (rx_ch_q == rss_pkg::CH_SEMI);
  wire         ch_cr     = rx_done_q & (rx_ch_q == rss_pkg::CH_CR);
  wire         ch_text   = rx_done_q & ~ch_lf & ~ch_sep & ~ch_cr;
  wire         is_opcq   = ch_lf & (seg_len_q == 3'd5) & (seg_q == rss_pkg::TXT_OPCQ);
  wire         is_opc    = ch_lf & (seg_len_q == 3'd4) & (seg_q[27:0] == rss_pkg::TXT_OPC);
  wire         is_rst    = (ch_lf | ch_sep) & (seg_len_q == 3'd4) & (seg_q[27:0] == rss_pkg::TXT_RST);
  wire         op_done   = ~op_busy;
  wire         opc_fire  = opc_arm_q & op_done;
  wire         opcq_fire = opcq_pend_q & op_done;

  // CR is dropped so that LF and CR LF end a message alike
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seg_q     <= '0;
      seg_len_q <= '0;
    end else if (ch_lf | ch_sep) begin
      seg_q     <= '0;
      seg_len_q <= '0;
    end else if (ch_text) begin
      seg_q     <= {seg_q[27:0], rx_ch_q};
      seg_len_q <= (seg_len_q == 3'd6) ? seg_len_q : seg_len_q + 3'd1;
    end
  end

  // Parsing runs on regardless of pending completions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opc_arm_q   <= 1'b0;
      opcq_pend_q <= 1'b0;
    end else begin
      opc_arm_q   <= is_opc | (opc_arm_q & ~op_done & ~is_rst);
      opcq_pend_q <= is_opcq | (opcq_pend_q & ~opcq_fire & ~is_rst);
    end
  end

  // ----------------------------------------
  // Output buffer and response injector
  // ----------------------------------------
  rss_pkg::rss_inj_t inj_q;
  rss_pkg::rss_inj_t inj_d;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [6:0]        fifo_out_data;
  logic              fifo_empty;
  logic              tx_take;
  logic              sw_push;
  logic [6:0]        inj_ch;
  wire               inj_act   = (inj_q != rss_pkg::RSS_INJ_IDLE);
  wire               fifo_push = inj_act | sw_push;
  wire [6:0]         fifo_din  = inj_act ? inj_ch : avs_writedata[6:0];

  always_comb begin
    inj_d  = inj_q;
    inj_ch = rss_pkg::CH_ONE;
    case (inj_q)
      rss_pkg::RSS_INJ_IDLE: begin
        if (opcq_fire) begin
          inj_d = rss_pkg::RSS_INJ_ONE;
        end
      end
      rss_pkg::RSS_INJ_ONE: begin
        inj_ch = rss_pkg::CH_ONE;
        if (fifo_in_ready) begin
          inj_d = rss_pkg::RSS_INJ_CR;
        end
      end
      rss_pkg::RSS_INJ_CR: begin
        inj_ch = rss_pkg::CH_CR;
        if (fifo_in_ready) begin
          inj_d = rss_pkg::RSS_INJ_LF;
        end
      end
      rss_pkg::RSS_INJ_LF: begin
        inj_ch = rss_pkg::CH_LF;
        if (fifo_in_ready) begin
          inj_d = rss_pkg::RSS_INJ_IDLE;
        end
      end
      default: begin
        inj_d = rss_pkg::RSS_INJ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inj_q <= rss_pkg::RSS_INJ_IDLE;
    end else begin
      inj_q <= inj_d;
    end
  end

  rss_fifo #(
    .WIDTH (rss_pkg::DATA_BITS),
    .DEPTH (rss_pkg::FIFO_DEPTH)
  ) u_outbuf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_din),
    .out_valid (fifo_out_valid),
    .out_ready (tx_take),
    .out_data  (fifo_out_data),
    .empty     (fifo_empty)
  );

  // ----------------------------------------
  // Transmitter, no handshake with the host
  // ----------------------------------------
  logic        tx_act_q;
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  wire         tx_tick = tx_act_q & (tx_cnt_q == '0);

  assign tx_take = ~tx_act_q;
  assign tx_pin  = tx_sh_q[0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_act_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q  <= 10'h3ff;
    end else if (tx_take & fifo_out_valid) begin
      tx_act_q <= 1'b1;
      tx_cnt_q <= rss_pkg::BIT_CNT_MAX;
      tx_bit_q <= '0;
      tx_sh_q  <= {1'b1, ~(^fifo_out_data), fifo_out_data, 1'b0};
    end else if (tx_tick) begin
      tx_cnt_q <= rss_pkg::BIT_CNT_MAX;
      tx_bit_q <= tx_bit_q + 4'h1;
      tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
      tx_act_q <= (tx_bit_q != rss_pkg::FRAME_LAST);
    end else if (tx_act_q) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // Status byte and service request
  // ----------------------------------------
  logic [7:0] sre_q;
  logic [7:0] ese_q;
  logic [7:0] esr_q;
  logic [7:0] summ_q;
  logic       rqs_q;
  logic [6:0] rxd_q;
  logic       rxv_q;
  logic       rxpe_q;
  logic       rxfe_q;
  logic       rxov_q;
  logic [7:0] stb;
  logic [7:0] summ;
  wire        mav    = ~fifo_empty;
  wire        esb    = |(esr_q & ese_q);

  assign stb    = {op_summary, 1'b0, esb, mav, 4'h0};
  assign summ   = stb & sre_q & ~(8'h01 << rss_pkg::STB_RQS);
  wire   mss    = |summ;
  wire   rise   = |(summ & ~summ_q);
  assign srq    = rqs_q;

  // ----------------------------------------
  // Avalon slave: one wait state per access, more for a TXD write while tx_stall holds
  // ----------------------------------------
  logic        ack_q;
  logic [31:0] rdata_q;
  wire         req      = avs_read | avs_write;
  wire         a_stb    = (avs_address == rss_pkg::OFS_STB);
  wire         a_sre    = (avs_address == rss_pkg::OFS_SRE);
  wire         a_esr    = (avs_address == rss_pkg::OFS_ESR);
  wire         a_spoll  = (avs_address == rss_pkg::OFS_SPOLL);
  wire         a_txd    = (avs_address == rss_pkg::OFS_TXD);
  wire         a_rxd    = (avs_address == rss_pkg::OFS_RXD);
  wire         a_ctl    = (avs_address == rss_pkg::OFS_CTL);
  wire         a_ese    = (avs_address == rss_pkg::OFS_ESE);
  // Response writes wait while a query holds the bus or the buffer is full
  wire         tx_stall = avs_write & a_txd & (~fifo_in_ready | inj_act | opcq_pend_q);
  wire         done     = req & ack_q;
  wire         wr_done  = done & avs_write;
  wire         rd_done  = done & avs_read;
  wire [7:0]   stb_rd   = stb | ({7'h00, mss} << rss_pkg::STB_RQS);
  wire [7:0]   poll_rd  = stb | ({7'h00, rqs_q} << rss_pkg::STB_RQS);
  logic [31:0] rd_mux;

  assign sw_push         = wr_done & a_txd;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  always_comb begin
    if (a_stb) begin
      rd_mux = {24'h000000, stb_rd};
    end else if (a_sre) begin
      rd_mux = {24'h000000, sre_q};
    end else if (a_esr) begin
      rd_mux = {24'h000000, esr_q};
    end else if (a_spoll) begin
      rd_mux = {24'h000000, poll_rd};
    end else if (a_rxd) begin
      rd_mux = {22'h000000, rxfe_q, rxpe_q, rxv_q, rxd_q};
    end else if (a_ctl) begin
      rd_mux = {29'h00000000, rxov_q, opcq_pend_q, opc_arm_q};
    end else if (a_ese) begin
      rd_mux = {24'h000000, ese_q};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= req & ~ack_q & ~tx_stall;
      rdata_q <= (avs_read & ~ack_q) ? rd_mux : rdata_q;
    end
  end

  // Sets win over clears throughout
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sre_q  <= rss_pkg::SRE_RESET;
      ese_q  <= rss_pkg::ESE_RESET;
      esr_q  <= '0;
      summ_q <= '0;
      rqs_q  <= 1'b0;
    end else begin
      summ_q <= summ;
      if (wr_done & a_sre) begin
        sre_q <= avs_writedata[7:0];
      end
      if (wr_done & a_ese) begin
        ese_q <= avs_writedata[7:0];
      end
      if (rd_done & a_esr) begin
        esr_q <= 8'h00;
      end
      if (opc_fire) begin
        esr_q[rss_pkg::ESR_OPC] <= 1'b1;
      end
      rqs_q <= rise | (rqs_q & ~(rd_done & a_spoll));
    end
  end

  // Received characters reach software through a single holding register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxd_q  <= '0;
      rxv_q  <= 1'b0;
      rxpe_q <= 1'b0;
      rxfe_q <= 1'b0;
      rxov_q <= 1'b0;
    end else begin
      if (rx_done_q) begin
        rxd_q  <= rx_ch_q;
        rxpe_q <= rx_perr_q;
        rxfe_q <= rx_ferr_q;
      end
      rxv_q  <= rx_done_q | (rxv_q & ~(rd_done & a_rxd));
      rxov_q <= (rx_done_q & rxv_q & ~(rd_done & a_rxd)) | (rxov_q & ~(wr_done & a_ctl));
    end
  end
endmodule
`default_nettype wire

// ===== inc/rss_pkg.sv
package rss_pkg;
  // ----------------------------------------
  // Clock and serial timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned BAUD_RATE    = 57_600;
  localparam int unsigned BIT_CYC      = CLK_HZ / BAUD_RATE;
  localparam logic [15:0] BIT_CNT_MAX  = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_CNT     = 16'(BIT_CYC / 2);
  localparam int unsigned DATA_BITS    = 7;
  localparam logic [3:0]  FRAME_LAST   = 4'h9;
  localparam logic [3:0]  PARITY_POS   = 4'h8;
  // ----------------------------------------
  // Buffer
  // ----------------------------------------
  localparam int unsigned FIFO_DEPTH   = 16;
  // ----------------------------------------
  // Characters
  // ----------------------------------------
  localparam logic [6:0]  CH_LF        = 7'h0a;
  localparam logic [6:0]  CH_CR        = 7'h0d;
  localparam logic [6:0]  CH_SEMI      = 7'h3b;
  localparam logic [6:0]  CH_ONE       = 7'h31;
  localparam logic [34:0] TXT_OPCQ     = {7'h2a, 7'h4f, 7'h50, 7'h43, 7'h3f};
  localparam logic [27:0] TXT_OPC      = {7'h2a, 7'h4f, 7'h50, 7'h43};
  localparam logic [27:0] TXT_RST      = {7'h2a, 7'h52, 7'h53, 7'h54};
  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0]  OFS_STB      = 8'h00;
  localparam logic [7:0]  OFS_SRE      = 8'h04;
  localparam logic [7:0]  OFS_ESR      = 8'h08;
  localparam logic [7:0]  OFS_SPOLL    = 8'h0c;
  localparam logic [7:0]  OFS_TXD      = 8'h10;
  localparam logic [7:0]  OFS_RXD      = 8'h14;
  localparam logic [7:0]  OFS_CTL      = 8'h18;
  localparam logic [7:0]  OFS_ESE      = 8'h1c;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned STB_OSB      = 7;
  localparam int unsigned STB_RQS      = 6;
  localparam int unsigned STB_ESB      = 5;
  localparam int unsigned STB_MAV      = 4;
  localparam int unsigned ESR_OPC      = 0;
  localparam int unsigned RXD_VALID    = 7;
  localparam int unsigned RXD_PERR     = 8;
  localparam int unsigned RXD_FERR     = 9;
  localparam logic [7:0]  SRE_RESET    = 8'h00;
  localparam logic [7:0]  ESE_RESET    = 8'h00;

  typedef enum logic [1:0] {
    RSS_INJ_IDLE = 2'b00,
    RSS_INJ_ONE  = 2'b01,
    RSS_INJ_CR   = 2'b10,
    RSS_INJ_LF   = 2'b11
  } rss_inj_t;
endpackage

// ===== hdl/rss_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module rss_fifo #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  empty
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             ov_q;
  logic [WIDTH-1:0] od_q;
  wire              push     = in_valid & in_ready;
  wire              load     = (cnt_q != '0) & (~ov_q | out_ready);
  wire              pop_out  = out_valid & out_ready;

  // ----------------------------------------
  // Storage plus a registered output stage
  // ----------------------------------------
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = ov_q;
  assign out_data  = od_q;
  assign empty     = ~ov_q & (cnt_q == '0);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (load) begin
        rd_q <= rd_q + 1'b1;
        od_q <= mem[rd_q];
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
      ov_q  <= load | (ov_q & ~pop_out);
    end
  end
endmodule
`default_nettype wire

// ===== tb/rss_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rss_host_model (
  input  wire logic clk,
  output logic      line_out,
  input  wire logic line_in
);
  // ----------------------------------------
  // Host serial port, no flow control
  // ----------------------------------------
  logic [7:0] rxq[$];
  logic [9:0] fr;

  initial line_out = 1'b1;

  task automatic send_str(input string s);
    byte        c;
    logic [9:0] f;
    for (int i = 0; i < s.len(); i++) begin
      c = s[i];
      f = {1'b1, ~^c[6:0], c[6:0], 1'b0};
      for (int b = 0; b < 10; b++) begin
        @(posedge clk);
        line_out <= f[b];
        repeat (rss_pkg::BIT_CYC - 1) @(posedge clk);
      end
    end
  endtask

  // Sampled mid-bit; bit 7 of each entry flags a bad frame or parity
  initial begin
    forever begin
      @(posedge clk);
      if (line_in === 1'b0) begin
        repeat (rss_pkg::BIT_CYC / 2) @(posedge clk);
        fr[0] = line_in;
        for (int b = 1; b < 10; b++) begin
          repeat (rss_pkg::BIT_CYC) @(posedge clk);
          fr[b] = line_in;
        end
        rxq.push_back({fr[0] | !fr[9] | !(^fr[8:1]), fr[7:1]});
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/rss_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rss_top_asserts (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_pin,
  input wire logic        tx_pin,
  input wire logic        op_busy,
  input wire logic        op_summary,
  input wire logic        srq
);
  // ----------------------------------------
  // Frame sampler on the serial output
  // ----------------------------------------
  logic [15:0] fcnt_q;
  logic [3:0]  bidx_q;
  logic        busy_q;
  logic        par_q;
  logic [15:0] run_q;
  wire         mid   = busy_q && (fcnt_q == rss_pkg::HALF_CNT);
  wire         wrap  = fcnt_q == rss_pkg::BIT_CNT_MAX;
  wire         spoll = avs_read && !avs_waitrequest && (avs_address == rss_pkg::OFS_SPOLL);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      fcnt_q <= 16'h0000;
      bidx_q <= 4'h0;
      par_q  <= 1'b0;
    end else if (!busy_q) begin
      busy_q <= !tx_pin;
      fcnt_q <= 16'h0000;
      bidx_q <= 4'h0;
      par_q  <= 1'b0;
    end else begin
      fcnt_q <= wrap ? 16'h0000 : fcnt_q + 16'h0001;
      bidx_q <= wrap ? bidx_q + 4'h1 : bidx_q;
      par_q  <= mid ? par_q ^ tx_pin : par_q;
      busy_q <= !(mid && bidx_q == 4'h9);
    end
  end

  // Counts cycles since the line last changed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= $changed(tx_pin) ? 16'h0000 : run_q + 16'h0001;
    end
  end

  // Cycles the line has stayed high since a read showed a waiting message
  logic [15:0] mwait_q;
  logic        marm_q;
  wire         mav_seen = avs_read && !avs_waitrequest && (avs_address == rss_pkg::OFS_STB)
                          && avs_readdata[rss_pkg::STB_MAV];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      marm_q  <= 1'b0;
      mwait_q <= 16'h0000;
    end else if (!tx_pin) begin
      marm_q  <= 1'b0;
      mwait_q <= 16'h0000;
    end else if (mav_seen || marm_q) begin
      marm_q  <= 1'b1;
      mwait_q <= mwait_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_bus_answered: assert property ((avs_read || avs_write) && avs_waitrequest && avs_address != rss_pkg::OFS_TXD
    |=> !avs_waitrequest) else $error("request not answered after one wait state");
  a_rdata_stands: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data changed without a read");
  a_mav_drains: assert property (marm_q |-> mwait_q < 16'h1130) else $error("waiting message never sent");
  a_spoll_clear: assert property (spoll && srq |=> !srq) else $error("serial poll left srq set");
  a_srq_keep: assert property ($fell(srq) |-> $past(spoll)) else $error("srq dropped without poll");
  a_start_low: assert property (mid && bidx_q == 4'h0 |-> !tx_pin) else $error("start bit not low");
  a_stop_high: assert property (mid && bidx_q == 4'h9 |-> tx_pin) else $error("stop bit not high");
  a_parity_odd: assert property (mid && bidx_q == 4'h9 |-> par_q) else $error("parity not odd");
  a_bit_time: assert property ($rose(tx_pin) |-> ((32'(run_q) + 1) % rss_pkg::BIT_CYC == 0)
    && (run_q < 16'h0d90)) else $error("low run not whole bit times");

  c_srq_rise: cover property ($rose(srq));
  c_txd_stall: cover property ((avs_write && avs_waitrequest) [*8]);
  c_frame_end: cover property (mid && bidx_q == 4'h9);
endmodule

bind rss_top rss_top_asserts rss_top_asserts_i (
  .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .op_busy(op_busy), .op_summary(op_summary), .srq(srq)
);
`default_nettype wire

// ===== tb/rss_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module rss_top_test;
  logic        clk           = 1'b0;
  logic        reset_n       = 1'b0;
  logic [7:0]  avs_address   = 8'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic        op_busy       = 1'b0;
  logic        op_summary    = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_pin;
  logic        tx_pin;
  logic        srq;
  logic [31:0] q;
  int          n;
  int          num_errors    = 0;
  int          check_count   = 0;

  always #20 clk = ~clk;

  rss_top rss_top_i (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .op_busy(op_busy), .op_summary(op_summary), .srq(srq)
  );
  rss_host_model rss_host_model_i (.clk(clk), .line_out(rx_pin), .line_in(tx_pin));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge; the answer is taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output int w);
    w = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge clk);
      w++;
    end while (avs_waitrequest !== 1'b0 && w < 20000);
    rd = avs_readdata;
    if (w >= 20000) num_errors++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q, n);
    chk(q & m, e);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({30'h0, tx_pin, srq}, 32'h2);
    rdc(rss_pkg::OFS_SRE, 32'hff, 32'h0);
    rdc(rss_pkg::OFS_ESE, 32'hff, 32'h0);
    rdc(rss_pkg::OFS_STB, 32'hff, 32'h0);
    rdc(8'h40, 32'hffff_ffff, 32'h0);
  endtask

  // Two characters first: the transmitter takes one at once, the other keeps the buffer non-empty
  task automatic t_fill;
    int w [19];
    bus(1'b1, rss_pkg::OFS_SRE, 32'h10, q, n);
    bus(1'b1, rss_pkg::OFS_TXD, 32'h41, q, n);
    bus(1'b1, rss_pkg::OFS_TXD, 32'h42, q, n);
    rdc(rss_pkg::OFS_STB, 32'h10, 32'h10);
    chk({31'h0, srq}, 32'h1);
    rdc(rss_pkg::OFS_SPOLL, 32'h40, 32'h40);
    @(negedge clk);
    chk({31'h0, srq}, 32'h0);
    for (int i = 2; i < 19; i++) begin
      bus(1'b1, rss_pkg::OFS_TXD, 32'h41 + i, q, n);
      w[i] = n;
    end
    chk(32'(w[15] < 4), 32'h1);
    chk(32'(w[18] > 100), 32'h1);
    @(negedge clk);
    chk({24'h0, rss_host_model_i.rxq[0]}, 32'h41);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4400) @(posedge clk);
    rdc(rss_pkg::OFS_STB, 32'h10, 32'h0);
    rss_host_model_i.rxq.delete();
  endtask

  task automatic t_opc;
    bus(1'b1, rss_pkg::OFS_ESE, 32'h1, q, n);
    bus(1'b1, rss_pkg::OFS_SRE, 32'h20, q, n);
    @(posedge clk);
    op_busy <= 1'b1;
    rss_host_model_i.send_str("*OPC\n");
    repeat (20) @(posedge clk);
    rdc(rss_pkg::OFS_ESR, 32'h1, 32'h0);
    rdc(rss_pkg::OFS_RXD, 32'h3ff, 32'h08a);
    @(posedge clk);
    op_busy <= 1'b0;
    repeat (4) @(negedge clk);
    chk({31'h0, srq}, 32'h1);
    rdc(rss_pkg::OFS_ESR, 32'h1, 32'h1);
    rdc(rss_pkg::OFS_ESR, 32'h1, 32'h0);
  endtask

  task automatic t_opcq;
    int k;
    @(posedge clk);
    op_busy <= 1'b1;
    rss_host_model_i.send_str("*OPC?\r\n");
    repeat (20) @(posedge clk);
    rdc(rss_pkg::OFS_STB, 32'h10, 32'h0);
    fork
      begin
        repeat (300) @(posedge clk);
        op_busy <= 1'b0;
      end
      bus(1'b1, rss_pkg::OFS_TXD, 32'h5a, q, n);
    join
    chk(32'(n > 300), 32'h1);
    k = 0;
    while (rss_host_model_i.rxq.size() < 4 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    chk({rss_host_model_i.rxq[0], rss_host_model_i.rxq[1], rss_host_model_i.rxq[2],
         rss_host_model_i.rxq[3]}, 32'h310d0a5a);
    rdc(rss_pkg::OFS_ESR, 32'h1, 32'h0);
    rdc(rss_pkg::OFS_STB, 32'h10, 32'h0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_fill();
    t_opc();
    t_opcq();
    give_verdict();
  end

  initial begin
    repeat (95000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
